// ### hw/mfd_decoder.sv
// Multifunction contact input decoder
`include "mfd_defs.svh"

// Behaviour
// - Local input closed: operator reference and run; open: remote source.
// - Option input open selects option card; change accepted only while stopped.
// - Three step inputs plus jog select pick one of nine references.
// - Master step uses preset 1 in operator mode; aux uses preset 2 when ctrl bits 15:8 are nonzero.
// - Accel input closed selects second time pair, even mid ramp.
// - Baseblock closed gates output, shows indication, restarts on release.
// - Baseblock during stop deceleration gates output and forces zero frequency.
// - Open-contact baseblock acts like closed-contact baseblock, inverted.
// - Hold freezes output; stop releases; stored value survives restart.
// - Overheat input raises minor alarm while operation continues.
// - UP alone accelerates, DOWN alone decelerates, both or neither hold.
// - UP/DOWN work only when reference source is terminals.
// - UP/DOWN upper limit is max frequency scaled by upper limit.
// - Lower limit is largest of min frequency, lower limit, master reference.
// - UP/DOWN run starts at lower limit; stored hold value reused.
// - Jog commands take priority over any other speed command.
// - Forward and reverse jog inputs run at jog preset while closed.
// - Both jog inputs closed for 500 ms stop the drive.
// - Codes 2X to 5X assign external faults 5 to 8 with indication.
// - Config bit 0 sets contact polarity; bit 1 running-only detection.
// - Config bits 3:2 select ramp, coast, ramp decel two, or continue.
// - Fault indication shows the terminal number of the fault input.
// - Minor fault indication stays at least half a second.
// - Several faults: coast beats ramp decel two beats plain ramp.
module mfd_decoder
	import mfd_pkg::*;
#(
	parameter int FW           = 16,
	parameter int NT           = 4,
	parameter int DEBOUNCE_CYC = `MFD_DEBOUNCE_CYC,
	parameter int JOG_BOTH_CYC = `MFD_JOG_BOTH_CYC,
	parameter int MINOR_CYC    = `MFD_MINOR_CYC
) (
	// Clock and reset
	input  wire logic          clock,
	input  wire logic          reset_n,
	// Register port
	input  wire logic [5:0]    reg_addr,
	input  wire logic [15:0]   reg_wdata,
	input  wire logic          reg_write,
	input  wire logic          reg_read,
	output logic      [15:0]   reg_rdata,
	// Contact terminals
	input  wire logic [NT-1:0] terminal_in,
	// Drive state
	input  wire logic          run_cmd,
	input  wire logic          running,
	input  wire logic          stopping,
	input  wire logic [FW-1:0] out_freq,
	input  wire logic [FW-1:0] master_ref,
	input  wire logic [FW-1:0] aux_ref,
	// Decoded controls
	output logic      [FW-1:0] freq_ref,
	output logic               local_mode,
	output logic               option_ref,
	output logic               remote_serial,
	output logic               up_clamp,
	output logic               down_clamp,
	output mfd_drive_type      drive,
	output mfd_fault_type      fault
);
	localparam int CW = 32;

	logic [7:0]    func [NT];
	logic [7:0]    next_func [NT];
	logic [FW-1:0] preset [9];
	logic [FW-1:0] next_preset [9];
	logic [15:0]   ctrl;
	logic [15:0]   next_ctrl;
	logic [FW-1:0] maxf;
	logic [FW-1:0] next_maxf;
	logic [FW-1:0] minf;
	logic [FW-1:0] next_minf;
	logic [7:0]    ulim;
	logic [7:0]    next_ulim;
	logic [FW-1:0] llim;
	logic [FW-1:0] next_llim;
	logic [15:0]   next_rdata;

	logic [NT-1:0] sync1;
	logic [NT-1:0] sync2;
	logic [NT-1:0] level;
	logic [NT-1:0] detect;
	logic [NT-1:0] is_fault;
	logic [NT-1:0] fmajor;
	logic [NT-1:0] next_fmajor;
	logic [NT-1:0] fminor;
	logic          fclr;

	// Synchroniser, debounce and minor hold time per terminal
	for (genvar i = 0; i < NT; i++) begin : g_term
		logic [CW-1:0] db_cnt;
		logic [CW-1:0] next_db_cnt;
		logic          next_level;
		logic [CW-1:0] mn_cnt;
		logic [CW-1:0] next_mn_cnt;
		logic          pol;
		logic          run_only;

		assign is_fault[i] = func[i][7:4] >= 4'h2 && func[i][7:4] <= 4'h5;
		assign pol         = func[i][0];
		assign run_only    = func[i][1];
		// Polarity and run-only qualification
		assign detect[i]   = is_fault[i] && (level[i] ^ pol) && (!run_only || running);

		always_comb begin
			next_level  = level[i];
			next_db_cnt = db_cnt;
			if (sync2[i] == level[i]) begin
				next_db_cnt = '0;
			end else if (db_cnt >= CW'(DEBOUNCE_CYC - 1)) begin
				next_level  = sync2[i];
				next_db_cnt = '0;
			end else begin
				next_db_cnt = db_cnt + 1'b1;
			end
			next_mn_cnt = mn_cnt;
			if (detect[i]) begin
				next_mn_cnt = CW'(MINOR_CYC);
			end else if (mn_cnt != '0) begin
				next_mn_cnt = mn_cnt - 1'b1;
			end
		end

		always_ff @(posedge clock) begin
			if (!reset_n) begin
				sync1[i] <= 1'b0;
				sync2[i] <= 1'b0;
				level[i] <= 1'b0;
				db_cnt   <= '0;
				mn_cnt   <= '0;
			end else begin
				sync1[i] <= terminal_in[i];
				sync2[i] <= sync1[i];
				level[i] <= next_level;
				db_cnt   <= next_db_cnt;
				mn_cnt   <= next_mn_cnt;
			end
		end

		assign fminor[i] = is_fault[i] && func[i][3:2] == 2'b11 && (detect[i] || mn_cnt != '0);
	end

	// Function decode: several terminals on one function are ORed
	logic fn_local, fn_option, fn_jogsel, fn_accel2, fn_bb_no, fn_bb_nc;
	logic has_bb_nc, fn_hold, fn_oh, fn_up, fn_down, fn_forward_jog_cmd, fn_reverse_jog_cmd;
	logic has_up, has_down;
	logic [2:0] step;

	always_comb begin
		fn_local  = 1'b0;
		fn_option = 1'b0;
		fn_jogsel = 1'b0;
		fn_accel2 = 1'b0;
		fn_bb_no  = 1'b0;
		fn_bb_nc  = 1'b0;
		has_bb_nc = 1'b0;
		fn_hold   = 1'b0;
		fn_oh     = 1'b0;
		fn_up     = 1'b0;
		fn_down   = 1'b0;
		has_up    = 1'b0;
		has_down  = 1'b0;
		fn_forward_jog_cmd   = 1'b0;
		fn_reverse_jog_cmd   = 1'b0;
		step      = 3'h0;
		for (int i = 0; i < NT; i++) begin
			unique case (func[i])
				`MFD_FN_LOCAL:    fn_local  |= level[i];
				`MFD_FN_OPTION:   fn_option |= level[i];
				`MFD_FN_STEP1:    step[0]   |= level[i];
				`MFD_FN_STEP2:    step[1]   |= level[i];
				`MFD_FN_STEP3:    step[2]   |= level[i];
				`MFD_FN_JOGSEL:   fn_jogsel |= level[i];
				`MFD_FN_ACCEL2:   fn_accel2 |= level[i];
				`MFD_FN_BB_NO:    fn_bb_no  |= level[i];
				`MFD_FN_BB_NC: begin
					has_bb_nc = 1'b1;
					fn_bb_nc  |= !level[i];
				end
				`MFD_FN_HOLD:     fn_hold   |= level[i];
				`MFD_FN_OVERHEAT: fn_oh     |= level[i];
				`MFD_FN_UP: begin
					has_up = 1'b1;
					fn_up  |= level[i];
				end
				`MFD_FN_DOWN: begin
					has_down = 1'b1;
					fn_down  |= level[i];
				end
				`MFD_FN_FORWARD_JOG_CMD:     fn_forward_jog_cmd   |= level[i];
				`MFD_FN_REVERSE_JOG_CMD:     fn_reverse_jog_cmd   |= level[i];
				default: ;
			endcase
		end
	end

	// Drive control state
	logic          run_q;
	logic          bb_q;
	logic          fzero;
	logic          next_fzero;
	logic [FW-1:0] stored;
	logic [FW-1:0] next_stored;
	logic          stored_ok;
	logic          next_stored_ok;
	logic [CW-1:0] jog_cnt;
	logic [CW-1:0] next_jog_cnt;
	logic          next_local;
	logic          next_option;
	logic [FW-1:0] next_freq_ref;
	mfd_drive_type next_drive;
	mfd_fault_type next_fault;
	logic          next_up_clamp;
	logic          next_down_clamp;

	logic            bb;
	logic            updown;
	logic            ud_hold;
	logic [FW+7:0]   prod;
	logic [FW-1:0]   upper;
	logic [FW-1:0]   lower;
	logic [FW-1:0]   step_ref;
	logic            jog_both;
	logic            jog_run;

	assign bb      = fn_bb_no || (has_bb_nc && fn_bb_nc);
	assign updown  = has_up && has_down && !ctrl[`MFD_CTRL_REFSRC];
	assign ud_hold = fn_up == fn_down;
	assign prod    = maxf * ulim;
	assign upper   = prod[FW+7:8];
	assign jog_both = fn_forward_jog_cmd && fn_reverse_jog_cmd;
	assign jog_run = (fn_forward_jog_cmd ^ fn_reverse_jog_cmd) || fn_jogsel;

	always_comb begin
		lower = minf;
		if (llim > lower) begin
			lower = llim;
		end
		if (master_ref > lower) begin
			lower = master_ref;
		end
		// Step selection; master and aux fall back to presets
		unique case (step)
			3'h0: step_ref = ctrl[`MFD_CTRL_REFSRC] ? preset[0] : master_ref;
			3'h1: step_ref = ctrl[15:8] != 8'h00 ? preset[1] : aux_ref;
			default: step_ref = preset[step];
		endcase
	end

	always_comb begin
		next_local     = local_mode;
		next_option    = option_ref;
		if (!running) begin
			next_local  = fn_local;
			next_option = !fn_option;
		end
		next_fzero = fzero;
		if (bb && stopping) begin
			next_fzero = 1'b1;
		end else if (run_cmd && !stopping && !bb) begin
			next_fzero = 1'b0;
		end
		next_jog_cnt = jog_both ? jog_cnt : '0;
		if (jog_both && jog_cnt < CW'(JOG_BOTH_CYC)) begin
			next_jog_cnt = jog_cnt + 1'b1;
		end
		next_stored    = stored;
		next_stored_ok = stored_ok;
		if (fn_hold) begin
			if (run_cmd && !stored_ok) begin
				next_stored    = out_freq;
				next_stored_ok = 1'b1;
			end
		end else if (updown) begin
			if (run_cmd && !run_q && !ud_hold) begin
				next_stored_ok = 1'b0;
			end else if (running && !ud_hold) begin
				next_stored    = out_freq < lower ? lower : (out_freq > upper ? upper : out_freq);
				next_stored_ok = 1'b1;
			end
		end else begin
			next_stored_ok = 1'b0;
		end
		if (reg_write && reg_addr == `MFD_OFS_STORED) begin
			next_stored    = reg_wdata[FW-1:0];
			next_stored_ok = 1'b1;
		end
		// Reference priority: jog, hold, UP/DOWN, steps
		if (jog_run && !jog_both) begin
			next_freq_ref = preset[8];
		end else if (fn_hold && stored_ok) begin
			next_freq_ref = stored;
		end else if (updown) begin
			if (fn_up && !fn_down) begin
				next_freq_ref = upper;
			end else if (fn_down && !fn_up) begin
				next_freq_ref = lower;
			end else begin
				next_freq_ref = stored_ok ? stored : lower;
			end
		end else begin
			next_freq_ref = step_ref;
		end
		next_up_clamp   = updown && fn_up && !fn_down && out_freq >= upper;
		next_down_clamp = updown && fn_down && !fn_up && out_freq <= lower;

		next_drive.gate_off                   = bb || fzero;
		next_drive.output_gate_off_indication = bb && (running || stopping);
		next_drive.force_zero                 = next_fzero;
		next_drive.restart                    = bb_q && !bb && run_cmd && !fzero;
		// Stop command drops the freeze
		next_drive.ramp_hold       = fn_hold && run_cmd && stored_ok && out_freq == stored;
		next_drive.accel_pair_two  = fn_accel2;
		next_drive.forward_jog_cmd = fn_forward_jog_cmd && !fn_reverse_jog_cmd;
		next_drive.reverse_jog_cmd = fn_reverse_jog_cmd && !fn_forward_jog_cmd;
		next_drive.jog_stop        = jog_cnt >= CW'(JOG_BOTH_CYC);

		next_fault                = '0;
		next_fault.minor          = fminor;
		next_fault.overheat_alarm = fn_oh;
		for (int i = NT - 1; i >= 0; i--) begin
			next_fmajor[i] = fmajor[i];
			if (fclr && !running) begin
				next_fmajor[i] = 1'b0;
			end
			// A new detection wins over a clear
			if (detect[i] && func[i][3:2] != 2'b11) begin
				next_fmajor[i] = 1'b1;
			end
			if (next_fmajor[i] || fminor[i]) begin
				next_fault.terminal = `MFD_FAULT_TERM0 + 4'(i);
			end
		end
		next_fault.major = next_fmajor;
		for (int i = 0; i < NT; i++) begin
			if (next_fmajor[i]) begin
				unique case (func[i][3:2])
					2'b01: next_fault.stop = STOP_COAST;
					2'b10: if (next_fault.stop != STOP_COAST) begin
						next_fault.stop = STOP_RAMP_DECEL_TWO;
					end
					default: if (next_fault.stop == STOP_NONE) begin
						next_fault.stop = STOP_RAMP;
					end
				endcase
			end
		end
	end

	// Register file
	assign fclr = reg_write && reg_addr == `MFD_OFS_FCLR;

	always_comb begin
		next_func   = func;
		next_preset = preset;
		next_ctrl   = ctrl;
		next_maxf   = maxf;
		next_minf   = minf;
		next_ulim   = ulim;
		next_llim   = llim;
		if (reg_write) begin
			for (int i = 0; i < NT; i++) begin
				if (reg_addr == `MFD_OFS_FUNC + 6'(i)) begin
					next_func[i] = reg_wdata[7:0];
				end
			end
			for (int i = 0; i < 9; i++) begin
				if (reg_addr == `MFD_OFS_PRESET + 6'(i)) begin
					next_preset[i] = reg_wdata[FW-1:0];
				end
			end
			unique case (reg_addr)
				`MFD_OFS_CTRL: next_ctrl = reg_wdata;
				`MFD_OFS_MAXF: next_maxf = reg_wdata[FW-1:0];
				`MFD_OFS_MINF: next_minf = reg_wdata[FW-1:0];
				`MFD_OFS_ULIM: next_ulim = reg_wdata[7:0];
				`MFD_OFS_LLIM: next_llim = reg_wdata[FW-1:0];
				default: ;
			endcase
		end
		next_rdata = 16'h0000;
		if (reg_read) begin
			for (int i = 0; i < NT; i++) begin
				if (reg_addr == `MFD_OFS_FUNC + 6'(i)) begin
					next_rdata = {8'h00, func[i]};
				end
			end
			for (int i = 0; i < 9; i++) begin
				if (reg_addr == `MFD_OFS_PRESET + 6'(i)) begin
					next_rdata = 16'(preset[i]);
				end
			end
			unique case (reg_addr)
				`MFD_OFS_CTRL:   next_rdata = ctrl;
				`MFD_OFS_MAXF:   next_rdata = 16'(maxf);
				`MFD_OFS_MINF:   next_rdata = 16'(minf);
				`MFD_OFS_ULIM:   next_rdata = {8'h00, ulim};
				`MFD_OFS_LLIM:   next_rdata = 16'(llim);
				`MFD_OFS_STORED: next_rdata = 16'(stored);
				`MFD_OFS_STATUS: next_rdata = {3'h0, stored_ok, fault.minor, fault.major, level};
				default: ;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			for (int i = 0; i < NT; i++) begin
				func[i] <= `MFD_FUNC_RST;
			end
			for (int i = 0; i < 9; i++) begin
				preset[i] <= `MFD_FREQ_RST;
			end
			ctrl       <= `MFD_CTRL_RST;
			maxf       <= `MFD_MAXF_RST;
			minf       <= `MFD_FREQ_RST;
			ulim       <= `MFD_ULIM_RST;
			llim       <= `MFD_FREQ_RST;
			reg_rdata  <= 16'h0000;
			run_q      <= 1'b0;
			bb_q       <= 1'b0;
			fzero      <= 1'b0;
			stored     <= `MFD_FREQ_RST;
			stored_ok  <= 1'b0;
			jog_cnt    <= '0;
			fmajor     <= '0;
			local_mode <= 1'b0;
			option_ref <= 1'b1;
			freq_ref   <= '0;
			up_clamp   <= 1'b0;
			down_clamp <= 1'b0;
			drive      <= '0;
			fault      <= '0;
		end else begin
			func       <= next_func;
			preset     <= next_preset;
			ctrl       <= next_ctrl;
			maxf       <= next_maxf;
			minf       <= next_minf;
			ulim       <= next_ulim;
			llim       <= next_llim;
			reg_rdata  <= next_rdata;
			run_q      <= run_cmd;
			bb_q       <= bb;
			fzero      <= next_fzero;
			stored     <= next_stored;
			stored_ok  <= next_stored_ok;
			jog_cnt    <= next_jog_cnt;
			fmajor     <= next_fmajor;
			local_mode <= next_local;
			option_ref <= next_option;
			freq_ref   <= next_freq_ref;
			up_clamp   <= next_up_clamp;
			down_clamp <= next_down_clamp;
			drive      <= next_drive;
			fault      <= next_fault;
		end
	end

	assign remote_serial = ctrl[`MFD_CTRL_RUNSRC];
endmodule

// ### include/mfd_defs.svh
// Constants for the multifunction input decoder
`ifndef MFD_DEFS_SVH
`define MFD_DEFS_SVH
`define MFD_CLK_MHZ        250
`define MFD_DEBOUNCE_US    1000
`define MFD_DEBOUNCE_CYC   (`MFD_DEBOUNCE_US * `MFD_CLK_MHZ)
`define MFD_JOG_BOTH_MS    500
`define MFD_JOG_BOTH_CYC   (`MFD_JOG_BOTH_MS * 1000 * `MFD_CLK_MHZ)
`define MFD_MINOR_MS       500
`define MFD_MINOR_CYC      (`MFD_MINOR_MS * 1000 * `MFD_CLK_MHZ)
`define MFD_OFS_FUNC       6'h00
`define MFD_OFS_CTRL       6'h04
`define MFD_OFS_PRESET     6'h08
`define MFD_OFS_MAXF       6'h11
`define MFD_OFS_MINF       6'h12
`define MFD_OFS_ULIM       6'h13
`define MFD_OFS_LLIM       6'h14
`define MFD_OFS_STORED     6'h15
`define MFD_OFS_STATUS     6'h16
`define MFD_OFS_FCLR       6'h17
`define MFD_CTRL_REFSRC    0
`define MFD_CTRL_RUNSRC    1
`define MFD_FUNC_RST       8'hff
`define MFD_CTRL_RST       16'h0000
`define MFD_FREQ_RST       16'h0000
`define MFD_MAXF_RST       16'h1770
`define MFD_ULIM_RST       8'hff
`define MFD_FN_LOCAL       8'h01
`define MFD_FN_OPTION      8'h02
`define MFD_FN_STEP1       8'h03
`define MFD_FN_STEP2       8'h04
`define MFD_FN_STEP3       8'h05
`define MFD_FN_JOGSEL      8'h06
`define MFD_FN_ACCEL2      8'h07
`define MFD_FN_BB_NO       8'h08
`define MFD_FN_BB_NC       8'h09
`define MFD_FN_HOLD        8'h0a
`define MFD_FN_OVERHEAT    8'h0b
`define MFD_FN_UP          8'h10
`define MFD_FN_DOWN        8'h11
`define MFD_FN_FORWARD_JOG_CMD        8'h12
`define MFD_FN_REVERSE_JOG_CMD        8'h13
`define MFD_FAULT_TERM0    4'h5
`endif

// ### include/mfd_pkg.sv
// Types shared by the multifunction input decoder
package mfd_pkg;
	typedef enum logic [1:0] {
		STOP_NONE,
		STOP_RAMP,
		STOP_RAMP_DECEL_TWO,
		STOP_COAST
	} mfd_stop_kind_type;

	typedef struct packed {
		logic gate_off;
		logic output_gate_off_indication;
		logic force_zero;
		logic restart;
		logic ramp_hold;
		logic accel_pair_two;
		logic forward_jog_cmd;
		logic reverse_jog_cmd;
		logic jog_stop;
	} mfd_drive_type;

	typedef struct packed {
		logic [3:0]        major;
		logic [3:0]        minor;
		logic              overheat_alarm;
		mfd_stop_kind_type stop;
		logic [3:0]        terminal;
	} mfd_fault_type;
endpackage

// ### tb/mfd_decoder_props.sv
// Port checks for the multifunction input decoder
module mfd_decoder_props
	import mfd_pkg::*;
#(
	parameter int FW           = 16,
	parameter int NT           = 4,
	parameter int DEBOUNCE_CYC = 4,
	parameter int JOG_BOTH_CYC = 20,
	parameter int MINOR_CYC    = 10
) (
	// Clock and reset
	input wire logic          clock,
	input wire logic          reset_n,
	// Register writes
	input wire logic [5:0]    reg_addr,
	input wire logic [15:0]   reg_wdata,
	input wire logic          reg_write,
	// Terminals and drive state
	input wire logic [NT-1:0] terminal_in,
	input wire logic          stopping,
	// Decoded controls
	input wire logic [FW-1:0] freq_ref,
	input wire mfd_drive_type drive,
	input wire mfd_fault_type fault
);
	logic [15:0]   stable_cnt, next_stable_cnt, both_cnt, next_both_cnt;
	logic [FW-1:0] jog_q, next_jog_q;
	logic [NT-1:0] term_q, next_term_q;

	// Counters saturate so a long idle stretch cannot wrap them
	always_comb begin
		next_term_q = terminal_in;
		next_stable_cnt = stable_cnt + 16'(stable_cnt != 16'hffff);
		next_both_cnt = both_cnt + 16'(both_cnt != 16'hffff);
		next_jog_q = jog_q;
		if (terminal_in != term_q)
			next_stable_cnt = 16'h0000;
		if ($countones(terminal_in) < 2)
			next_both_cnt = 16'h0000;
		if (reg_write && reg_addr == 6'h10)
			next_jog_q = reg_wdata[FW-1:0];
		if (!reset_n) begin
			next_stable_cnt = 16'h0000;
			next_both_cnt = 16'h0000;
			next_jog_q = '0;
		end
	end

	always_ff @(posedge clock) begin
		term_q <= next_term_q;
		stable_cnt <= next_stable_cnt;
		both_cnt <= next_both_cnt;
		jog_q <= next_jog_q;
	end

	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);

	sequence minor_up;
		$rose(fault.minor != 4'h0);
	endsequence
	sequence minor_kept;
		(fault.minor != 4'h0) [*8];
	endsequence

	minor_hold_a: assert property (minor_up |-> minor_kept)
		else $error("minor fault indication dropped early");
	stop_major_a: assert property ((fault.major != 4'h0) == (fault.stop != STOP_NONE))
		else $error("stop kind does not match major faults");
	fault_term_a: assert property ((fault.major | fault.minor) != 4'h0 |->
		fault.terminal inside {[4'h5:4'h8]}) else $error("fault terminal out of range");
	bb_gate_a: assert property (drive.output_gate_off_indication |-> drive.gate_off)
		else $error("indication without gated output");
	zero_cause_a: assert property ($rose(drive.force_zero) |->
		$past(stopping) && drive.gate_off) else $error("zero frequency without cause");
	jog_stop_a: assert property ($rose(drive.jog_stop) |-> both_cnt >= JOG_BOTH_CYC)
		else $error("jog stop before both jogs held long enough");
	debounce_a: assert property ($rose(drive.gate_off) |-> stable_cnt >= DEBOUNCE_CYC)
		else $error("gate followed an unsettled contact");
	jog_ref_a: assert property ($rose(drive.forward_jog_cmd) |->
		##[0:2] freq_ref == jog_q) else $error("jog run without jog reference");
endmodule

bind mfd_decoder mfd_decoder_props #(
	.FW(FW), .NT(NT), .DEBOUNCE_CYC(DEBOUNCE_CYC), .JOG_BOTH_CYC(JOG_BOTH_CYC),
	.MINOR_CYC(MINOR_CYC)
) mfd_decoder_props_i (
	.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_write(reg_write), .terminal_in(terminal_in), .stopping(stopping),
	.freq_ref(freq_ref), .drive(drive), .fault(fault)
);

// ### tb/mfd_contacts.sv
// Contact sequence at the terminals, with optional chatter
module mfd_contacts #(
	parameter int NT = 4
) (
	// Clock
	input  wire logic          clock,
	// Commanded contact state
	input  wire logic [NT-1:0] want,
	input  wire logic          chatter,
	// Terminal levels
	output logic      [NT-1:0] pins
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [NT-1:0] held = '0;
	logic [NT-1:0] mask = '0;
	logic [2:0]    left = 3'h0;
	initial pins = '0;
	// Bouncing contacts flip the moving bits a few times before settling
	always @(posedge clock) begin
		if (want != held) begin
			held <= want;
			mask <= want ^ held;
			left <= chatter ? 3'h5 : 3'h0;
			pins <= chatter ? pins ^ want ^ held : want;
		end else if (left != 3'h0) begin
			left <= left - 3'h1;
			pins <= (left == 3'h1) ? held : pins ^ mask;
		end
	end
endmodule

// ### tb/tb.sv
// Self-checking bench for the multifunction input decoder
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin n_errors++; \
	$display("CHECK FAILED %s expected %h seen %h", n, e, a); end end
module tb
	import mfd_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock = 0, reset_n = 0, reg_write = 0, reg_read = 0, chatter = 0, rd_q = 0;
	logic run_cmd = 0, running = 0, stopping = 0;
	logic local_mode, option_ref, remote_serial, up_clamp, down_clamp;
	logic [5:0]  reg_addr = 0;
	logic [15:0] reg_wdata = 0, out_freq = 0, master_ref = 0, aux_ref = 0;
	logic [15:0] reg_rdata, freq_ref, got_e;
	logic [3:0]  terminal_in, want = 0;
	logic [15:0] p[0:8];
	logic [15:0] exq[$];
	mfd_drive_type drive;
	mfd_fault_type fault;
	int n_errors = 0, samples_checked = 0, seed = 33;
	int n_restart = 0;

	always #2 clock = ~clock;

	mfd_contacts #(.NT(4)) mfd_contacts_i (
		.clock(clock), .want(want), .chatter(chatter), .pins(terminal_in));

	// Short counts keep the run brief; minor hold long enough to tell from debounce
	mfd_decoder #(.DEBOUNCE_CYC(4), .JOG_BOTH_CYC(20), .MINOR_CYC(40)) mfd_decoder_i (
		.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.terminal_in(terminal_in), .run_cmd(run_cmd), .running(running),
		.stopping(stopping), .out_freq(out_freq), .master_ref(master_ref),
		.aux_ref(aux_ref), .freq_ref(freq_ref), .local_mode(local_mode),
		.option_ref(option_ref), .remote_serial(remote_serial), .up_clamp(up_clamp),
		.down_clamp(down_clamp), .drive(drive), .fault(fault));

	task automatic close_out;
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask

	task automatic rd(input logic [5:0] a, input logic [15:0] e);
		exq.push_back(e);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
	endtask

	// Sync and debounce take under ten cycles; sixteen leaves margin for chatter
	task automatic setc(input logic [3:0] v);
		@(posedge clock);
		want <= v;
		chatter <= ~chatter;
		repeat (16) @(posedge clock);
		#1;
	endtask

	task automatic fn4(input logic [31:0] f);
		for (int i = 0; i < 4; i++)
			wr(6'(i), {8'h00, f[8*i +: 8]});
	endtask

	task automatic drv(input logic rc, input logic rn, input logic st);
		@(posedge clock);
		run_cmd <= rc;
		running <= rn;
		stopping <= st;
	endtask

	// Read data stand only in the cycle after the strobe
	always @(posedge clock) begin
		rd_q <= reg_read;
		if (rd_q) begin
			got_e = exq.pop_front();
			`CHK("reg_rdata", got_e, reg_rdata)
		end
	end

	// Restart lasts one cycle, so count it while it stands
	always @(posedge clock) begin
		if (drive.restart === 1'b1) begin
			n_restart++;
		end
	end

	initial begin
		repeat (6000) @(posedge clock);
		n_errors++;
		close_out();
	end

	initial begin
		logic [2:0]  s;
		logic [15:0] e;
		repeat (20) @(posedge clock);
		#1;
		`CHK("option_ref", 1'b1, option_ref)
		`CHK("fault", 16'h0000, 16'(fault))
		@(posedge clock);
		reset_n <= 1'b1;
		rd(6'h00, 16'h00ff);
		rd(6'h11, 16'h1770);
		rd(6'h13, 16'h00ff);
		rd(6'h3f, 16'h0000);
		// Local and option selection follow the contacts only when stopped
		fn4(32'hffff0201);
		setc(4'b0011);
		`CHK("local_mode", 1'b1, local_mode)
		`CHK("option_ref", 1'b0, option_ref)
		drv(1, 1, 0);
		setc(4'b0000);
		`CHK("option_ref", 1'b0, option_ref)
		drv(0, 0, 0);
		setc(4'b0000);
		`CHK("local_mode", 1'b0, local_mode)
		`CHK("option_ref", 1'b1, option_ref)
		// Step and jog selection across all combinations and modes
		for (int i = 0; i < 9; i++) begin
			p[i] = 16'($random(seed));
			wr(6'h08 + 6'(i), p[i]);
		end
		rd(6'h08, p[0]);
		master_ref <= 16'($random(seed));
		aux_ref <= 16'($random(seed));
		fn4(32'h06050403);
		for (int m = 0; m < 3; m++) begin
			wr(6'h04, m == 1 ? 16'h0001 : (m == 2 ? 16'h0100 : 16'h0000));
			for (int c = 0; c < 16; c++) begin
				setc(4'(c));
				s = 3'(c);
				e = s == 3'h0 ? (m == 1 ? p[0] : master_ref) :
					s == 3'h1 ? (m == 2 ? p[1] : aux_ref) : p[s];
				e = c[3] ? p[8] : e;
				`CHK("freq_ref", e, freq_ref)
			end
		end
		// External faults: coast NC run-only, decel two, ramp, continue
		drv(1, 1, 0);
		setc(4'b0001);
		fn4(32'h5c403827);
		setc(4'b0101);
		`CHK("stop", STOP_RAMP, fault.stop)
		`CHK("terminal", 4'h7, fault.terminal)
		`CHK("major", 4'h4, fault.major)
		setc(4'b0111);
		`CHK("stop", STOP_RAMP_DECEL_TWO, fault.stop)
		`CHK("terminal", 4'h6, fault.terminal)
		setc(4'b0110);
		`CHK("stop", STOP_COAST, fault.stop)
		`CHK("major", 4'h7, fault.major)
		@(posedge clock);
		want <= 4'b1110;
		repeat (9) @(posedge clock);
		want <= 4'b0110;
		repeat (15) @(posedge clock);
		#1;
		`CHK("minor", 4'h8, fault.minor)
		repeat (40) @(posedge clock);
		setc(4'b0001);
		drv(0, 0, 0);
		wr(6'h17, 16'h000f);
		setc(4'b0000);
		`CHK("major", 4'h0, fault.major)
		`CHK("stop", STOP_NONE, fault.stop)
		// Baseblock both polarities, time pair, overheat
		fn4(32'h0b070908);
		drv(1, 1, 0);
		setc(4'b0011);
		`CHK("gate_off", 2'b11, {drive.gate_off, drive.output_gate_off_indication})
		setc(4'b0010);
		`CHK("gate_off", 1'b0, drive.gate_off)
		`CHK("restart", 1, n_restart)
		setc(4'b0000);
		`CHK("gate_off", 2'b11, {drive.gate_off, drive.output_gate_off_indication})
		setc(4'b1110);
		`CHK("accel_two", 1'b1, drive.accel_pair_two)
		`CHK("overheat", 1'b1, fault.overheat_alarm)
		drv(1, 1, 1);
		setc(4'b1111);
		`CHK("force_zero", 1'b1, drive.force_zero)
		drv(1, 1, 0);
		// Hold, then jogs overriding it
		fn4(32'hff0a1312);
		setc(4'b0100);
		`CHK("ramp_hold", 1'b1, drive.ramp_hold)
		drv(0, 1, 0);
		setc(4'b0100);
		`CHK("ramp_hold", 1'b0, drive.ramp_hold)
		drv(1, 1, 0);
		setc(4'b0101);
		`CHK("fwd_jog", 1'b1, drive.forward_jog_cmd)
		`CHK("freq_ref", p[8], freq_ref)
		setc(4'b0110);
		`CHK("rev_jog", 1'b1, drive.reverse_jog_cmd)
		setc(4'b0111);
		repeat (24) @(posedge clock);
		#1;
		`CHK("jog_stop", 1'b1, drive.jog_stop)
		// UP and DOWN limits
		fn4(32'hffff1110);
		wr(6'h04, 16'h0002);
		wr(6'h13, 16'h0080);
		wr(6'h12, 16'h0064);
		wr(6'h14, 16'h00c8);
		master_ref <= 16'h012c;
		out_freq <= 16'h0bb8;
		setc(4'b0001);
		`CHK("up_clamp", 1'b1, up_clamp)
		`CHK("remote_serial", 1'b1, remote_serial)
		`CHK("freq_ref", 16'h0bb8, freq_ref)
		wr(6'h04, 16'h0001);
		setc(4'b0001);
		`CHK("up_clamp", 1'b0, up_clamp)
		`CHK("remote_serial", 1'b0, remote_serial)
		wr(6'h04, 16'h0000);
		out_freq <= 16'h012c;
		setc(4'b0010);
		`CHK("down_clamp", 1'b1, down_clamp)
		`CHK("freq_ref", 16'h012c, freq_ref)
		rd(6'h15, 16'h012c);
		rd(6'h16, 16'h1002);
		// Let the last read reach its checker before the verdict
		repeat (2) @(posedge clock);
		close_out();
	end
endmodule
